// *** rtl/smr_pkg.sv ***
`default_nettype none
package smr_pkg;

   // Configuration offsets and reset values of the two control registers.
   localparam logic [7:0]  SMR_CTRL_OFS   = 8'h9D;
   localparam logic [7:0]  SMR_EXT_OFS    = 8'h9E;
   localparam logic [7:0]  SMR_CTRL_RST   = 8'h02;
   localparam logic [7:0]  SMR_EXT_RST    = 8'h38;

   // Field positions in the SMM RAM control register.
   localparam int          SMR_OPEN_BIT   = 6;
   localparam int          SMR_CLOSED_BIT = 5;
   localparam int          SMR_LOCK_BIT   = 4;
   localparam int          SMR_GLOBAL_BIT = 3;
   localparam logic [2:0]  SMR_BASE_SEG   = 3'h2;

   // Field positions in the extended SMM RAM control register.
   localparam int          SMR_HIGH_BIT   = 7;
   localparam int          SMR_FLAG_BIT   = 6;
   localparam int          SMR_SIZE_LSB   = 1;
   localparam int          SMR_SEG_EN_BIT = 0;
   localparam logic [2:0]  SMR_EXT_RSVD   = 3'h7;

   // Address windows and the top segment geometry.
   localparam logic [31:0] SMR_COMPAT_LO  = 32'h000A0000;
   localparam logic [31:0] SMR_COMPAT_END = 32'h000BFFFF;
   localparam logic [31:0] SMR_HIGH_LO    = 32'hFEDA0000;
   localparam logic [31:0] SMR_HIGH_END   = 32'hFEDAFFFF;
   localparam logic [32:0] SMR_SEG_MIN    = 33'h000020000;
   localparam logic [26:0] SMR_TOP_ZERO   = 27'h0000000;

   // Where a decoded request is sent.
   typedef enum logic [1:0] {
      SMR_ROUTE_NONE = 2'h0,
      SMR_ROUTE_DRAM = 2'h1,
      SMR_ROUTE_HUB  = 2'h3
   } smr_route_t;

endpackage
`default_nettype wire

// *** rtl/smr_window_dec.sv ***
`timescale 1ns/1ns
`default_nettype none
module smr_window_dec (
   input  wire logic [31:0] addr,
   input  wire logic [4:0]  low_memory_top,
   input  wire logic [1:0]  top_segment_size,
   output logic             compat_hit,
   output logic             high_hit,
   output logic             seg_hit
);
   import smr_pkg::*;

   logic [32:0] top;
   logic [32:0] size;
   logic [32:0] base;
   logic [32:0] a;

   // The top segment ends at the low memory top and grows down by size.
   always_comb begin
      a          = {1'b0, addr};
      top        = {1'b0, low_memory_top, SMR_TOP_ZERO};
      size       = 33'(SMR_SEG_MIN << top_segment_size);
      base       = top - size;
      compat_hit = (addr >= SMR_COMPAT_LO) && (addr <= SMR_COMPAT_END);
      high_hit   = (addr >= SMR_HIGH_LO) && (addr <= SMR_HIGH_END);
      seg_hit    = (top >= size) && (a >= base) && (a < top);
   end

endmodule
`default_nettype wire

// *** rtl/smr_sticky_flag.sv ***
`timescale 1ns/1ns
`default_nettype none
module smr_sticky_flag (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set,
   input  wire logic clr,
   output logic      flag_q
);

   // A set in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag_q <= 1'b0;
      end else if (set) begin
         flag_q <= 1'b1;
      end else if (clr) begin
         flag_q <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// *** rtl/smr_access_ctrl.sv ***
// Notes on behaviour
// - open, closed and lock act on decoding only while global enable is set.
// - open with lock clear makes compatible and high alias SMM DRAM visible to non-SMM requests.
// - closed denies data references to compatible SMM DRAM; code fetches pass.
// - closed affects only the compatible window, not high alias or top segment.
// - lock forces open to zero and freezes lock, open, high, size, segment enable.
// - lock is set by a normal write and stays set until reset.
// - with global enable, SMM requests to A0000h window use DRAM in place.
// - high alias and top segment work only with global enable set.
// - once locked, global enable ignores writes until reset.
// - base segment field reads 010b; compatible SMM DRAM is never relocated.
// - compatible accesses failing visibility go to the hub interface.
// - high alias FEDA0000h..FEDAFFFFh translates to DRAM from 000A0000h.
// - non-SMM access to high alias or top segment with open clear sets flag.
// - writing 1 clears the invalid access flag; writing 0 leaves it.
// - size code selects 128 KB, 256 KB, 512 KB or 1 MB below low memory top.
// - only SMM requests reach top segment DRAM; others go to the hub interface.
// - top segment is active only with global and segment enables set.
// - low memory top gives address bits 31:27; lower bits are zero.
`timescale 1ns/1ns
`default_nettype none
module smr_access_ctrl (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              cfg_wr,
   input  wire logic              cfg_rd,
   input  wire logic [7:0]        cfg_addr,
   input  wire logic [7:0]        cfg_wdata,
   output logic                   cfg_rvalid_q,
   output logic [7:0]             cfg_rdata_q,
   input  wire logic              req_valid,
   input  wire logic [31:0]       req_addr,
   input  wire logic              req_smm,
   input  wire logic              req_code,
   input  wire logic [4:0]        low_memory_top,
   output logic                   rsp_valid_q,
   output smr_pkg::smr_route_t    rsp_route_q,
   output logic [31:0]            rsp_dram_addr_q
);
   import smr_pkg::*;

   logic       smm_space_open_q;
   logic       smm_space_closed_q;
   logic       smm_space_lock_q;
   logic       global_smram_enable_q;
   logic       high_smram_enable_q;
   logic [1:0] top_segment_size_q;
   logic       top_segment_enable_q;
   logic       invalid_smram_access_flag_q;
   logic       ctrl_wr;
   logic       ext_wr;
   logic       lock_now;
   logic       open_eff;
   logic       high_on;
   logic       seg_on;
   logic       compat_hit;
   logic       high_hit;
   logic       seg_hit;
   logic       flag_set;
   logic       flag_clr;
   smr_route_t route_d;
   logic [31:0] dram_addr_d;

   // Configuration write strobes for the two registers.
   assign ctrl_wr  = cfg_wr && (cfg_addr == SMR_CTRL_OFS);
   assign ext_wr   = cfg_wr && (cfg_addr == SMR_EXT_OFS);
   assign lock_now = ctrl_wr && cfg_wdata[SMR_LOCK_BIT];

   // Lock is set by an ordinary write and only reset clears it.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         smm_space_lock_q <= 1'b0;
      end else if (lock_now) begin
         smm_space_lock_q <= 1'b1;
      end
   end

   // Open is forced low by lock, including the write that sets lock.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         smm_space_open_q <= 1'b0;
      end else if (smm_space_lock_q || lock_now) begin
         smm_space_open_q <= 1'b0;
      end else if (ctrl_wr) begin
         smm_space_open_q <= cfg_wdata[SMR_OPEN_BIT];
      end
   end

   // Closed stays writable after lock.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         smm_space_closed_q <= 1'b0;
      end else if (ctrl_wr) begin
         smm_space_closed_q <= cfg_wdata[SMR_CLOSED_BIT];
      end
   end

   // Global enable ignores writes once locked.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         global_smram_enable_q <= 1'b0;
      end else if (ctrl_wr && !smm_space_lock_q) begin
         global_smram_enable_q <= cfg_wdata[SMR_GLOBAL_BIT];
      end
   end

   // Extended fields freeze under lock.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         high_smram_enable_q  <= 1'b0;
         top_segment_size_q   <= 2'h0;
         top_segment_enable_q <= 1'b0;
      end else if (ext_wr && !smm_space_lock_q) begin
         high_smram_enable_q  <= cfg_wdata[SMR_HIGH_BIT];
         top_segment_size_q   <= cfg_wdata[SMR_SIZE_LSB+:2];
         top_segment_enable_q <= cfg_wdata[SMR_SEG_EN_BIT];
      end
   end

   // Register reads answer one cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_rvalid_q <= 1'b0;
         cfg_rdata_q  <= 8'h00;
      end else begin
         cfg_rvalid_q <= cfg_rd;
         if (cfg_rd && cfg_addr == SMR_CTRL_OFS) begin
            cfg_rdata_q <= {1'b0, smm_space_open_q, smm_space_closed_q,
                            smm_space_lock_q, global_smram_enable_q,
                            SMR_BASE_SEG};
         end else if (cfg_rd && cfg_addr == SMR_EXT_OFS) begin
            cfg_rdata_q <= {high_smram_enable_q, invalid_smram_access_flag_q,
                            SMR_EXT_RSVD, top_segment_size_q,
                            top_segment_enable_q};
         end else begin
            cfg_rdata_q <= 8'h00;
         end
      end
   end

   // Address windows of the current request.
   smr_window_dec u_dec (
      .addr             (req_addr),
      .low_memory_top   (low_memory_top),
      .top_segment_size (top_segment_size_q),
      .compat_hit       (compat_hit),
      .high_hit         (high_hit),
      .seg_hit          (seg_hit)
   );

   // Controls that qualify decoding; all hinge on global enable.
   assign open_eff = global_smram_enable_q && smm_space_open_q && !smm_space_lock_q;
   assign high_on  = global_smram_enable_q && high_smram_enable_q;
   assign seg_on   = global_smram_enable_q && top_segment_enable_q;

   // Non-SMM touches of the extended ranges with open clear raise the flag.
   assign flag_set = req_valid && !req_smm && !smm_space_open_q &&
                     ((high_on && high_hit) || (seg_on && seg_hit));
   assign flag_clr = ext_wr && cfg_wdata[SMR_FLAG_BIT];

   smr_sticky_flag u_flag (
      .clk    (clk),
      .rst_n  (rst_n),
      .set    (flag_set),
      .clr    (flag_clr),
      .flag_q (invalid_smram_access_flag_q)
   );

   // Routing decision taken in the cycle the address is presented.
   always_comb begin
      route_d     = SMR_ROUTE_NONE;
      dram_addr_d = req_addr;
      if (high_on && high_hit) begin
         dram_addr_d = SMR_COMPAT_LO | {16'h0000, req_addr[15:0]};
         route_d     = (req_smm || open_eff) ? SMR_ROUTE_DRAM : SMR_ROUTE_HUB;
      end else if (seg_on && seg_hit) begin
         route_d = req_smm ? SMR_ROUTE_DRAM : SMR_ROUTE_HUB;
      end else if (compat_hit) begin
         if (global_smram_enable_q &&
             (open_eff || (req_smm && (!smm_space_closed_q || req_code)))) begin
            route_d = SMR_ROUTE_DRAM;
         end else begin
            route_d = SMR_ROUTE_HUB;
         end
      end
   end

   // The answer to each request stands for one cycle.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp_valid_q     <= 1'b0;
         rsp_route_q     <= SMR_ROUTE_NONE;
         rsp_dram_addr_q <= 32'h00000000;
      end else begin
         rsp_valid_q     <= req_valid;
         rsp_route_q     <= req_valid ? route_d : SMR_ROUTE_NONE;
         rsp_dram_addr_q <= req_valid ? dram_addr_d : 32'h00000000;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Lock never falls without reset.
   a_lock_sticky: assert property (
      $past(smm_space_lock_q) |-> smm_space_lock_q)
      else $error("lock bit cleared without reset");

   // Lock holds open at zero.
   a_lock_open: assert property (
      smm_space_lock_q |-> !smm_space_open_q)
      else $error("open bit set while locked");

   // Locked fields keep their value across writes.
   a_lock_frozen: assert property (
      smm_space_lock_q && $past(smm_space_lock_q) |->
         $stable(high_smram_enable_q) && $stable(top_segment_size_q) &&
         $stable(top_segment_enable_q) && $stable(global_smram_enable_q))
      else $error("locked field changed");

   // The base segment field always reads back fixed.
   a_base_fixed: assert property (
      cfg_rd && cfg_addr == SMR_CTRL_OFS |=> cfg_rdata_q[2:0] == 3'h2 && cfg_rvalid_q)
      else $error("base segment field not 010b");

   // Without global enable nothing reaches SMM DRAM.
   a_gate_off: assert property (
      req_valid && !global_smram_enable_q |=> rsp_route_q != SMR_ROUTE_DRAM)
      else $error("DRAM route with global enable clear");

   // Open makes the compatible window visible outside SMM.
   a_open_vis: assert property (
      req_valid && compat_hit && open_eff |=> rsp_route_q == SMR_ROUTE_DRAM)
      else $error("open window not routed to DRAM");

   // Closed sends data references to the hub interface.
   a_closed_data: assert property (
      req_valid && compat_hit && smm_space_closed_q && !open_eff && !req_code
      |=> rsp_route_q == SMR_ROUTE_HUB)
      else $error("closed data reference reached DRAM");

   // SMM code fetches in the compatible window reach DRAM in place.
   a_compat_code: assert property (
      req_valid && compat_hit && global_smram_enable_q && req_smm && req_code
      |=> rsp_route_q == SMR_ROUTE_DRAM && rsp_dram_addr_q == $past(req_addr))
      else $error("SMM code fetch not served in place");

   // High alias translates and ignores closed.
   a_high_xlate: assert property (
      req_valid && high_on && high_hit && req_smm |=>
         rsp_route_q == SMR_ROUTE_DRAM &&
         rsp_dram_addr_q == {16'h000A, $past(req_addr[15:0])})
      else $error("high alias translation wrong");

   // Non-SMM top segment requests go to the hub interface.
   a_seg_nonsmm: assert property (
      req_valid && seg_on && seg_hit && !high_hit && !req_smm
      |=> rsp_route_q == SMR_ROUTE_HUB)
      else $error("non-SMM top segment access reached DRAM");

   // Top segment hits lie just below the low memory top.
   a_seg_bound: assert property (
      seg_hit |-> {1'b0, req_addr} < {1'b0, low_memory_top, SMR_TOP_ZERO} &&
         {1'b0, low_memory_top, SMR_TOP_ZERO} - {1'b0, req_addr} <=
         33'(SMR_SEG_MIN << top_segment_size_q))
      else $error("top segment hit outside its size");

   // Flag rises after an illegal extended access, even if cleared then.
   a_flag_set: assert property (
      flag_set |=> invalid_smram_access_flag_q)
      else $error("invalid access flag not set");

   // Writing 1 clears the flag, writing 0 keeps it.
   a_flag_clear: assert property (
      ext_wr && !flag_set |=>
         invalid_smram_access_flag_q == ($past(invalid_smram_access_flag_q) &&
                                         !$past(cfg_wdata[SMR_FLAG_BIT])))
      else $error("invalid access flag write behaviour wrong");

   // Each request gets exactly one answer cycle.
   a_rsp_timing: assert property (
      req_valid |=> rsp_valid_q ##0 $past(rsp_valid_q) == $past(req_valid, 2))
      else $error("response not one cycle after request");

   // Compatible requests with global enable clear go to the hub interface.
   a_compat_hub: assert property (
      req_valid && compat_hit && !global_smram_enable_q |=> rsp_route_q == SMR_ROUTE_HUB)
      else $error("compatible request with global enable clear not sent to hub interface");

   // A disabled top segment leaves its range undecoded.
   a_seg_off: assert property (
      req_valid && seg_hit && !seg_on && !compat_hit && !high_hit |=> rsp_route_q == SMR_ROUTE_NONE)
      else $error("disabled top segment still decoded");

   // SMM requests inside an active top segment reach DRAM in place.
   a_seg_smm: assert property (
      req_valid && seg_on && seg_hit && req_smm |=>
         rsp_route_q == SMR_ROUTE_DRAM && rsp_dram_addr_q == $past(req_addr))
      else $error("SMM top segment access not served from DRAM");

   // Open lets non-SMM requests use the high alias.
   a_high_open: assert property (
      req_valid && high_on && high_hit && open_eff |=> rsp_route_q == SMR_ROUTE_DRAM)
      else $error("open high alias not routed to DRAM");

   // A write that carries lock sets it on the next edge.
   a_lock_set: assert property (
      lock_now |=> smm_space_lock_q)
      else $error("lock bit not set by write");

   // Unlocked, global enable takes the written value, even in the locking write.
   a_global_write: assert property (
      ctrl_wr && !smm_space_lock_q |=> global_smram_enable_q == $past(cfg_wdata[SMR_GLOBAL_BIT]))
      else $error("global enable did not take written value");

   // Unlocked and not locking, open takes the written value.
   a_open_write: assert property (
      ctrl_wr && !smm_space_lock_q && !lock_now |=> smm_space_open_q == $past(cfg_wdata[SMR_OPEN_BIT]))
      else $error("open bit did not take written value");

   // Closed stays writable whether locked or not.
   a_closed_write: assert property (
      ctrl_wr |=> smm_space_closed_q == $past(cfg_wdata[SMR_CLOSED_BIT]))
      else $error("closed bit did not take written value");

   // The extended register reads back the flag and its reserved ones.
   a_ext_read: assert property (
      cfg_rd && cfg_addr == SMR_EXT_OFS |=> cfg_rvalid_q &&
         cfg_rdata_q[SMR_FLAG_BIT] == $past(invalid_smram_access_flag_q) && cfg_rdata_q[5:3] == SMR_EXT_RSVD)
      else $error("extended register read back wrong");

   // Without an event or a clear the flag keeps its value.
   a_flag_quiet: assert property (
      !flag_set && !flag_clr |=> $stable(invalid_smram_access_flag_q))
      else $error("invalid access flag changed without cause");

   // Without a request there is no answer.
   a_rsp_idle: assert property (
      !req_valid |=>
         !rsp_valid_q && rsp_route_q == SMR_ROUTE_NONE && rsp_dram_addr_q == 32'h00000000)
      else $error("answer without request");

   // Main scenarios.
   c_lock_set: cover property ($rose(smm_space_lock_q));
   c_high_dram: cover property (req_valid && high_on && high_hit && req_smm);
   c_seg_flag: cover property (flag_set && seg_hit);
   c_closed_code: cover property (req_valid && compat_hit && smm_space_closed_q && req_code);
   c_open_vis: cover property (req_valid && compat_hit && open_eff && !req_smm);

endmodule
`default_nettype wire

// *** tb/smr_cpu_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module smr_cpu_model (
   input  wire logic                clk,
   output logic                     req_valid,
   output logic [31:0]              req_addr,
   output logic                     req_smm,
   output logic                     req_code,
   input  wire logic                rsp_valid_q,
   input  wire smr_pkg::smr_route_t rsp_route_q,
   input  wire logic [31:0]         rsp_dram_addr_q
);
   import smr_pkg::*;

   // Request lines start idle with a pattern that no test expects to match.
   initial begin
      req_valid = 1'b0;
      req_addr  = 32'h5A5A5A5A;
      req_smm   = 1'b0;
      req_code  = 1'b0;
   end

   // Issues one request for a single cycle and takes the answer one cycle later.
   // The qualifiers are scrambled after release so stale values never pass for a hold.
   task automatic issue(input logic [31:0] a, input logic s, input logic c,
                        output smr_route_t rt, output logic [31:0] da, output logic ok);
      @(posedge clk);
      req_valid <= 1'b1;
      req_addr  <= a;
      req_smm   <= s;
      req_code  <= c;
      @(posedge clk);
      req_valid <= 1'b0;
      req_addr  <= ~a;
      req_smm   <= ~s;
      req_code  <= ~c;
      #1;
      ok = rsp_valid_q;
      rt = rsp_route_q;
      da = rsp_dram_addr_q;
   endtask

endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import smr_pkg::*;

   logic        clk            = 1'b0;
   logic        rst_n          = 1'b0;
   logic        cfg_wr         = 1'b0;
   logic        cfg_rd         = 1'b0;
   logic [7:0]  cfg_addr       = 8'h00;
   logic [7:0]  cfg_wdata      = 8'h00;
   logic [4:0]  low_memory_top = 5'h02;
   logic        cfg_rvalid_q;
   logic [7:0]  cfg_rdata_q;
   logic        req_valid;
   logic [31:0] req_addr;
   logic        req_smm;
   logic        req_code;
   logic        rsp_valid_q;
   smr_route_t  rsp_route_q;
   logic [31:0] rsp_dram_addr_q;
   int          n_fail         = 0;
   int          compares       = 0;

   // The clock toggles every half period of 10 ns.
   always #10 clk = ~clk;

   smr_access_ctrl dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rvalid_q(cfg_rvalid_q), .cfg_rdata_q(cfg_rdata_q), .req_valid(req_valid),
      .req_addr(req_addr), .req_smm(req_smm), .req_code(req_code), .low_memory_top(low_memory_top),
      .rsp_valid_q(rsp_valid_q), .rsp_route_q(rsp_route_q), .rsp_dram_addr_q(rsp_dram_addr_q));

   smr_cpu_model cpu (.clk(clk), .req_valid(req_valid), .req_addr(req_addr), .req_smm(req_smm),
      .req_code(req_code), .rsp_valid_q(rsp_valid_q), .rsp_route_q(rsp_route_q),
      .rsp_dram_addr_q(rsp_dram_addr_q));

   // Compares one value and reports a mismatch at once.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic results();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // One-cycle configuration write.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cfg_wr    <= 1'b1;
      cfg_addr  <= a;
      cfg_wdata <= d;
      @(posedge clk);
      cfg_wr <= 1'b0;
   endtask

   // One-cycle configuration read; the answer stands for one cycle only.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      cfg_rd   <= 1'b1;
      cfg_addr <= a;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      check("cfg_rvalid", {31'h0, cfg_rvalid_q}, 32'h1);
      check("cfg_rdata", {24'h0, cfg_rdata_q}, {24'h0, exp});
   endtask

   // One request through the processor model; the address is checked only for DRAM routes.
   task automatic rq(input logic [31:0] a, input logic s, input logic c, input smr_route_t er,
                     input logic [31:0] ea);
      smr_route_t  rt;
      logic [31:0] da;
      logic        ok;
      cpu.issue(a, s, c, rt, da, ok);
      check("rsp_valid", {31'h0, ok}, 32'h1);
      check("rsp_route", {30'h0, rt}, {30'h0, er});
      if (er == SMR_ROUTE_DRAM)
         check("rsp_dram_addr", da, ea);
   endtask

   task automatic done(input string t);
      $display("test %s finished", t);
   endtask

   // Cuts a hang short and counts it as a mismatch.
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("unexpected timeout expected finish seen hang");
      results();
   end

   // Main sequence of register and decode tests.
   initial begin
      logic [31:0] lo;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(SMR_CTRL_OFS, 8'h02);
      rd(SMR_EXT_OFS, 8'h38);
      rd(8'h9F, 8'h00);
      done("reset");
      wr(SMR_CTRL_OFS, 8'h47);
      rd(SMR_CTRL_OFS, 8'h42);
      rq(32'h000A0000, 1'b0, 1'b0, SMR_ROUTE_HUB, 32'h0);
      rq(32'h000A0000, 1'b1, 1'b0, SMR_ROUTE_HUB, 32'h0);
      wr(SMR_EXT_OFS, 8'h83);
      rq(32'hFEDA0000, 1'b1, 1'b0, SMR_ROUTE_NONE, 32'h0);
      rq(32'h0FFC0000, 1'b1, 1'b0, SMR_ROUTE_NONE, 32'h0);
      rq(32'hFEDA0000, 1'b0, 1'b0, SMR_ROUTE_NONE, 32'h0);
      rd(SMR_EXT_OFS, 8'hBB);
      done("global_off");
      wr(SMR_CTRL_OFS, 8'h0A);
      rq(32'h000A0000, 1'b1, 1'b0, SMR_ROUTE_DRAM, 32'h000A0000);
      rq(32'h000BFFFF, 1'b1, 1'b0, SMR_ROUTE_DRAM, 32'h000BFFFF);
      rq(32'h000C0000, 1'b1, 1'b0, SMR_ROUTE_NONE, 32'h0);
      rq(32'h0009FFFF, 1'b1, 1'b0, SMR_ROUTE_NONE, 32'h0);
      rq(32'h000A0000, 1'b0, 1'b0, SMR_ROUTE_HUB, 32'h0);
      done("compat");
      wr(SMR_CTRL_OFS, 8'h4A);
      rq(32'h000B0000, 1'b0, 1'b0, SMR_ROUTE_DRAM, 32'h000B0000);
      rq(32'hFEDAFFFF, 1'b0, 1'b0, SMR_ROUTE_DRAM, 32'h000AFFFF);
      rq(32'h0FFC0000, 1'b0, 1'b0, SMR_ROUTE_HUB, 32'h0);
      rd(SMR_EXT_OFS, 8'hBB);
      done("open");
      wr(SMR_CTRL_OFS, 8'h2A);
      rq(32'h000A0000, 1'b1, 1'b0, SMR_ROUTE_HUB, 32'h0);
      rq(32'h000A0000, 1'b1, 1'b1, SMR_ROUTE_DRAM, 32'h000A0000);
      rq(32'hFEDA1234, 1'b1, 1'b0, SMR_ROUTE_DRAM, 32'h000A1234);
      rq(32'h0FFC0000, 1'b1, 1'b0, SMR_ROUTE_DRAM, 32'h0FFC0000);
      done("closed");
      rq(32'hFEDA0000, 1'b0, 1'b0, SMR_ROUTE_HUB, 32'h0);
      rd(SMR_EXT_OFS, 8'hFB);
      wr(SMR_EXT_OFS, 8'h83);
      rd(SMR_EXT_OFS, 8'hFB);
      wr(SMR_EXT_OFS, 8'hC3);
      rd(SMR_EXT_OFS, 8'hBB);
      rq(32'h0FFFFFFF, 1'b0, 1'b0, SMR_ROUTE_HUB, 32'h0);
      rd(SMR_EXT_OFS, 8'hFB);
      wr(SMR_EXT_OFS, 8'hC3);
      done("flag");
      for (int s = 0; s < 4; s++) begin
         wr(SMR_EXT_OFS, {1'b1, 4'h0, 2'(s), 1'b1});
         lo = 32'h10000000 - (32'h00020000 << s);
         rq(lo, 1'b1, 1'b0, SMR_ROUTE_DRAM, lo);
         rq(lo - 32'h1, 1'b1, 1'b0, SMR_ROUTE_NONE, 32'h0);
         rq(32'h0FFFFFFF, 1'b1, 1'b0, SMR_ROUTE_DRAM, 32'h0FFFFFFF);
         rq(32'h10000000, 1'b1, 1'b0, SMR_ROUTE_NONE, 32'h0);
      end
      @(posedge clk);
      low_memory_top <= 5'h03;
      rq(32'h17FFFFFF, 1'b1, 1'b0, SMR_ROUTE_DRAM, 32'h17FFFFFF);
      wr(SMR_EXT_OFS, 8'h82);
      rq(32'h17FFFFFF, 1'b1, 1'b0, SMR_ROUTE_NONE, 32'h0);
      done("top_segment");
      wr(SMR_CTRL_OFS, 8'h0A);
      wr(SMR_CTRL_OFS, 8'h1A);
      rd(SMR_CTRL_OFS, 8'h1A);
      wr(SMR_CTRL_OFS, 8'h42);
      rd(SMR_CTRL_OFS, 8'h1A);
      wr(SMR_EXT_OFS, 8'h01);
      rd(SMR_EXT_OFS, 8'hBA);
      wr(SMR_CTRL_OFS, 8'h3A);
      rd(SMR_CTRL_OFS, 8'h3A);
      rq(32'h000A0000, 1'b0, 1'b0, SMR_ROUTE_HUB, 32'h0);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(SMR_CTRL_OFS, 8'h02);
      rd(SMR_EXT_OFS, 8'h38);
      done("lock");
      results();
   end

endmodule
`default_nettype wire
